/* logic/bce_pkg.sv */
package bce_pkg;

  // ==========================================================================
  // Timing and sizes
  // ==========================================================================
  localparam logic [8:0] OP_CYCLES = 9'h177;  // 375 cycles from start to done
  localparam logic [8:0] OP_LAST   = 9'h176;  // Final busy cycle
  localparam logic [3:0] LAST_BYTE = 4'hF;    // Byte index 15 ends a block
  localparam logic [3:0] LAST_RND  = 4'h9;    // Tenth round / expansion step

  // ==========================================================================
  // Field arithmetic constants
  // ==========================================================================
  localparam logic [7:0] POLY      = 8'h1B;   // Reduction polynomial low byte
  localparam logic [7:0] RCON_INIT = 8'h01;   // First round constant
  localparam logic [7:0] AFF_FWD   = 8'h63;   // Substitution affine offset
  localparam logic [7:0] AFF_INV   = 8'h05;   // Inverse affine offset

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef logic [15:0][7:0] blk_t;            // Byte k = row k%4, column k/4

  typedef struct packed {
    logic start;       // Start one block operation
    logic decrypt;     // 1 decrypt, 0 encrypt
    logic auto_start;  // Start when byte 15 of state is written
    logic xor_load;    // State writes combine by exclusive-or
    logic irq_en;      // Allow completion interrupt
  } ctrl_t;

  typedef struct packed {
    logic       key_wr;  // Write next key byte
    logic       key_rd;  // Read next key byte
    logic       st_wr;   // Write next state byte
    logic       st_rd;   // Read next state byte
    logic [7:0] wdata;   // Write data
  } acc_t;

endpackage : bce_pkg

/* logic/block_cipher_engine.sv */
// Operation
// - Encrypt and decrypt 128-bit blocks, 128-bit key
// - Done after 375 cycles; result in state
// - Completion interrupt only when enabled
// - DMA trigger pulses on completion
// - Auto start once state fully loaded
// - XOR load mode combines with held state
`timescale 1ns/1ps
module block_cipher_engine (
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           rst_b,
  // Control
  input  wire bce_pkg::ctrl_t ctrl,
  // Byte access to key and state memories
  input  wire bce_pkg::acc_t  acc,
  output logic [7:0]          rdata_ff,
  // Status and events
  output logic                busy_ff,
  output logic                irq_ff,
  output logic                dma_trig_ff
);

  // ==========================================================================
  // Field and cipher functions
  // ==========================================================================
  // Multiply by x modulo the field polynomial
  function automatic logic [7:0] xt(input logic [7:0] b);
    return {b[6:0], 1'b0} ^ (b[7] ? bce_pkg::POLY : 8'h00);
  endfunction : xt

  // Undo xt, used to walk round constants downward
  function automatic logic [7:0] xinv(input logic [7:0] b);
    return b[0] ? (((b ^ bce_pkg::POLY) >> 1) | 8'h80) : (b >> 1);
  endfunction : xinv

  // General field product
  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h00;
    p = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) r = r ^ p;
      p = xt(p);
    end
    return r;
  endfunction : gmul

  // Field inverse as x^254; zero maps to zero. Costs area, saves a table.
  function automatic logic [7:0] ginv(input logic [7:0] x);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h01;
    p = x;
    for (int i = 0; i < 7; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r;
  endfunction : ginv

  // Rotate a byte left
  function automatic logic [7:0] rotl(input logic [7:0] b, input logic [2:0] n);
    logic [15:0] t;
    t = {b, b} << n;
    return t[15:8];
  endfunction : rotl

  // Forward substitution
  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] i;
    i = ginv(x);
    return i ^ rotl(i, 3'h1) ^ rotl(i, 3'h2) ^ rotl(i, 3'h3) ^ rotl(i, 3'h4)
           ^ bce_pkg::AFF_FWD;
  endfunction : sbox

  // Inverse substitution
  function automatic logic [7:0] isbox(input logic [7:0] x);
    return ginv(rotl(x, 3'h1) ^ rotl(x, 3'h3) ^ rotl(x, 3'h6) ^ bce_pkg::AFF_INV);
  endfunction : isbox

  // Row shift combined with substitution, per byte they commute
  function automatic bce_pkg::blk_t subsh(input bce_pkg::blk_t s, input logic inv);
    bce_pkg::blk_t o;
    int            src;
    o = '0;
    for (int k = 0; k < 16; k++) begin
      src = inv ? ((((k / 4) - (k % 4)) & 3) * 4 + (k % 4))
                : ((((k / 4) + (k % 4)) & 3) * 4 + (k % 4));
      o[k] = inv ? isbox(s[src]) : sbox(s[src]);
    end
    return o;
  endfunction : subsh

  // Column mixing coefficient by distance
  function automatic logic [7:0] coef(input int d, input logic inv);
    case (d)
      0:       return inv ? 8'h0E : 8'h02;
      1:       return inv ? 8'h0B : 8'h03;
      2:       return inv ? 8'h0D : 8'h01;
      default: return inv ? 8'h09 : 8'h01;
    endcase
  endfunction : coef

  // Column mixing, forward or inverse
  function automatic bce_pkg::blk_t mix(input bce_pkg::blk_t s, input logic inv);
    bce_pkg::blk_t o;
    o = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        for (int j = 0; j < 4; j++) begin
          o[4*c+r] = o[4*c+r] ^ gmul(s[4*c+j], coef((j - r) & 3, inv));
        end
      end
    end
    return o;
  endfunction : mix

  // Rotated, substituted last word plus round constant
  function automatic logic [3:0][7:0] kg(input bce_pkg::blk_t k, input logic [7:0] rc);
    return {sbox(k[12]), sbox(k[15]), sbox(k[14]), sbox(k[13]) ^ rc};
  endfunction : kg

  // Next round key
  function automatic bce_pkg::blk_t knext(input bce_pkg::blk_t k, input logic [7:0] rc);
    bce_pkg::blk_t    o;
    logic [3:0][7:0] t;
    t = kg(k, rc);
    o = '0;
    for (int i = 0; i < 4; i++) o[i] = k[i] ^ t[i];
    for (int i = 4; i < 16; i++) o[i] = k[i] ^ o[i-4];
    return o;
  endfunction : knext

  // Previous round key, lets decryption run keys backward
  function automatic bce_pkg::blk_t kprev(input bce_pkg::blk_t n, input logic [7:0] rc);
    bce_pkg::blk_t    o;
    logic [3:0][7:0] t;
    o = '0;
    for (int i = 4; i < 16; i++) o[i] = n[i] ^ n[i-4];
    t = kg(o, rc);
    for (int i = 0; i < 4; i++) o[i] = n[i] ^ t[i];
    return o;
  endfunction : kprev

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [2:0] {IDLE, EXPAND, ADDKEY, ROUND, HOLD} phase_t;

  phase_t        phase_ff;    // Sequencer phase
  bce_pkg::blk_t key_mem_ff;  // Key memory, 16 bytes
  bce_pkg::blk_t st_mem_ff;   // State memory, 16 bytes
  bce_pkg::blk_t rk_ff;       // Working round key
  logic [7:0]    rcon_ff;     // Round constant for next forward step
  logic [3:0]    rnd_ff;      // Round / expansion step
  logic [8:0]    cnt_ff;      // Cycles since start
  logic          dec_ff;      // Operation latched at start
  logic [3:0]    kidx_ff;     // Key byte index
  logic [3:0]    sidx_ff;     // State byte index

  // ==========================================================================
  // Decode and datapath
  // ==========================================================================
  wire           idle     = (phase_ff == IDLE);
  wire           key_wr   = idle & acc.key_wr;
  wire           key_rd   = idle & acc.key_rd;
  wire           st_wr    = idle & acc.st_wr;
  wire           st_rd    = idle & acc.st_rd;
  wire           auto_go  = st_wr & ctrl.auto_start & (sidx_ff == bce_pkg::LAST_BYTE);
  wire           go       = idle & (ctrl.start | auto_go);
  wire           done     = !idle & (cnt_ff == bce_pkg::OP_LAST);
  wire           last_rnd = (rnd_ff == bce_pkg::LAST_RND);
  wire [7:0]     rc_dn    = xinv(rcon_ff);
  wire bce_pkg::blk_t k_fwd = knext(rk_ff, rcon_ff);
  wire bce_pkg::blk_t k_bwd = kprev(rk_ff, rc_dn);
  wire bce_pkg::blk_t e_sub = subsh(st_mem_ff, 1'b0);
  wire bce_pkg::blk_t e_out = (last_rnd ? e_sub : mix(e_sub, 1'b0)) ^ k_fwd;
  wire bce_pkg::blk_t d_sub = subsh(st_mem_ff, 1'b1) ^ k_bwd;
  wire bce_pkg::blk_t d_out = last_rnd ? d_sub : mix(d_sub, 1'b1);
  wire [7:0]     st_in    = ctrl.xor_load ? (st_mem_ff[sidx_ff] ^ acc.wdata)
                                          : acc.wdata;

  // ==========================================================================
  // Sequencer: one round per cycle, then hold to the fixed latency
  // ==========================================================================
  // Rounds take at most 21 cycles; the hold keeps timing data-independent
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_ff <= IDLE;
      cnt_ff   <= 9'h000;
      rnd_ff   <= 4'h0;
      dec_ff   <= 1'b0;
    end else if (go) begin
      phase_ff <= ctrl.decrypt ? EXPAND : ADDKEY;  // Decrypt first runs key forward
      cnt_ff   <= 9'h000;
      rnd_ff   <= 4'h0;
      dec_ff   <= ctrl.decrypt;
    end else if (done) begin
      phase_ff <= IDLE;
    end else if (!idle) begin
      cnt_ff <= cnt_ff + 9'h001;
      unique case (phase_ff)
        EXPAND: begin
          rnd_ff   <= last_rnd ? 4'h0 : rnd_ff + 4'h1;
          phase_ff <= last_rnd ? ADDKEY : EXPAND;
        end
        ADDKEY: phase_ff <= ROUND;
        ROUND: begin
          rnd_ff   <= rnd_ff + 4'h1;
          phase_ff <= last_rnd ? HOLD : ROUND;
        end
        default: ;                                 // HOLD waits for the count
      endcase
    end
  end

  // Round key and constant walk forward, or backward when decrypting
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rk_ff   <= '0;
      rcon_ff <= 8'h00;
    end else if (go) begin
      rk_ff   <= key_mem_ff;
      rcon_ff <= bce_pkg::RCON_INIT;
    end else if (phase_ff == EXPAND || (phase_ff == ROUND && !dec_ff)) begin
      rk_ff   <= k_fwd;
      rcon_ff <= xt(rcon_ff);
    end else if (phase_ff == ROUND) begin
      rk_ff   <= k_bwd;
      rcon_ff <= rc_dn;
    end
  end

  // ==========================================================================
  // Memories and byte access
  // ==========================================================================
  // State memory: rounds have priority; host access only while idle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_mem_ff <= '0;
    end else if (phase_ff == ADDKEY) begin
      st_mem_ff <= st_mem_ff ^ rk_ff;
    end else if (phase_ff == ROUND) begin
      st_mem_ff <= dec_ff ? d_out : e_out;
    end else if (st_wr) begin
      st_mem_ff[sidx_ff] <= st_in;
    end
  end

  // Key memory is never altered by an operation, so it can be reused
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      key_mem_ff <= '0;
    end else if (key_wr) begin
      key_mem_ff[kidx_ff] <= acc.wdata;
    end
  end

  // Indices rewind at start and completion so readout begins at byte 0
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      kidx_ff  <= 4'h0;
      sidx_ff  <= 4'h0;
      rdata_ff <= 8'h00;
    end else if (go || done) begin
      kidx_ff <= 4'h0;
      sidx_ff <= 4'h0;
    end else begin
      if (key_wr || key_rd) kidx_ff <= kidx_ff + 4'h1;
      if (st_wr || st_rd) sidx_ff <= sidx_ff + 4'h1;
      if (key_rd) rdata_ff <= key_mem_ff[kidx_ff];
      else if (st_rd) rdata_ff <= st_mem_ff[sidx_ff];
    end
  end

  // ==========================================================================
  // Status and completion events
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff     <= 1'b0;
      irq_ff      <= 1'b0;
      dma_trig_ff <= 1'b0;
    end else begin
      busy_ff     <= go | (busy_ff & !done);
      irq_ff      <= done & ctrl.irq_en;
      dma_trig_ff <= done;
    end
  end

endmodule : block_cipher_engine

/* testbench/block_cipher_engine_monitor.sv */
`timescale 1ns/1ps
module block_cipher_engine_monitor (
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           rst_b,
  // Block ports
  input  wire bce_pkg::ctrl_t ctrl,
  input  wire bce_pkg::acc_t  acc,
  input  wire logic [7:0]     rdata_ff,
  input  wire logic           busy_ff,
  input  wire logic           irq_ff,
  input  wire logic           dma_trig_ff
);
  // ==========================================================================
  // Helper state
  // ==========================================================================
  logic [8:0] run_cnt_ff;   // Busy cycles so far
  logic [3:0] sidx_ff;      // Shadow state byte index
  // Index rewinds while busy, so a stale write count never leaks
  wire  [8:0] nxt_run_cnt = busy_ff ? run_cnt_ff + 9'h001 : 9'h000;
  // Reads move the state index as well as writes
  wire  [3:0] nxt_sidx    = busy_ff ? 4'h0 : sidx_ff + {3'h0, acc.st_wr | acc.st_rd};
  wire        go_auto     = !busy_ff && acc.st_wr && ctrl.auto_start &&
                            (sidx_ff == bce_pkg::LAST_BYTE);
  wire        go_any      = !busy_ff && (ctrl.start || go_auto);
  wire        rd_taken    = !busy_ff && (acc.key_rd || acc.st_rd);
  // Shadow counters
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_cnt_ff <= 9'h000;
      sidx_ff    <= 4'h0;
    end else begin
      run_cnt_ff <= nxt_run_cnt;
      sidx_ff    <= nxt_sidx;
    end
  end
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_start; !busy_ff && ctrl.start |=> busy_ff; endproperty
  property p_auto; go_auto |=> busy_ff; endproperty
  property p_idle; !busy_ff && !go_any |=> !busy_ff; endproperty
  property p_len; $fell(busy_ff) |-> run_cnt_ff == bce_pkg::OP_CYCLES; endproperty
  property p_max; busy_ff |-> run_cnt_ff < bce_pkg::OP_CYCLES; endproperty
  property p_dma_on; $fell(busy_ff) |-> dma_trig_ff; endproperty
  property p_dma_only; dma_trig_ff |-> $fell(busy_ff); endproperty
  property p_irq_gate; irq_ff |-> dma_trig_ff && $past(ctrl.irq_en); endproperty
  property p_irq_on; dma_trig_ff && $past(ctrl.irq_en) |-> irq_ff; endproperty
  property p_hold; !rd_taken |=> $stable(rdata_ff); endproperty
  a_start: assert property (p_start) else $error("start not taken");
  a_auto: assert property (p_auto) else $error("auto start missed");
  a_idle: assert property (p_idle) else $error("busy without cause");
  a_len: assert property (p_len) else $error("operation length wrong");
  a_max: assert property (p_max) else $error("operation too long");
  a_dma_on: assert property (p_dma_on) else $error("no trigger at done");
  a_dma_only: assert property (p_dma_only) else $error("stray trigger");
  a_irq_gate: assert property (p_irq_gate) else $error("stray interrupt");
  a_irq_on: assert property (p_irq_on) else $error("enabled interrupt missing");
  a_hold: assert property (p_hold) else $error("read data moved");
  // Main scenarios reached
  c_irq: cover property (dma_trig_ff && irq_ff);
  c_noirq: cover property (dma_trig_ff && !irq_ff);
  c_auto: cover property (go_auto);
  c_dec: cover property (!busy_ff && ctrl.start && ctrl.decrypt);
endmodule : block_cipher_engine_monitor

bind block_cipher_engine block_cipher_engine_monitor block_cipher_engine_monitor_inst (
  .core_clk(core_clk), .rst_b(rst_b), .ctrl(ctrl), .acc(acc), .rdata_ff(rdata_ff),
  .busy_ff(busy_ff), .irq_ff(irq_ff), .dma_trig_ff(dma_trig_ff));

/* testbench/block_cipher_engine_test.sv */
`timescale 1ns/1ps
module block_cipher_engine_test;
  // ==========================================================================
  // Signals and reference blocks, byte 0 lowest
  // ==========================================================================
  logic           core_clk;
  logic           rst_b;
  bce_pkg::ctrl_t ctrl;
  bce_pkg::acc_t  acc;
  logic [7:0]     rdata_ff;
  logic           busy_ff;
  logic           irq_ff;
  logic           dma_trig_ff;
  int             error_cnt = 0;
  int             checked = 0;
  // Bound on the busy wait, well above one operation
  localparam logic [8:0] RUN_LIMIT = 9'h1F4;
  localparam bce_pkg::blk_t KEY = 128'h0F0E0D0C0B0A09080706050403020100;
  localparam bce_pkg::blk_t PT  = 128'hFFEEDDCCBBAA99887766554433221100;
  localparam bce_pkg::blk_t CT  = 128'h5AC5B47080B7CDD830047B6AD8E0C469;

  block_cipher_engine block_cipher_engine_inst (
    .core_clk(core_clk), .rst_b(rst_b), .ctrl(ctrl), .acc(acc), .rdata_ff(rdata_ff),
    .busy_ff(busy_ff), .irq_ff(irq_ff), .dma_trig_ff(dma_trig_ff));

  // Free running clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task check(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task conclude;
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  // Sixteen back-to-back writes, byte 0 first
  task wr16(input logic key, input bce_pkg::blk_t d);
    bce_pkg::acc_t a;
    for (int i = 0; i <= 16; i++) begin
      a = '0;
      if (i < 16) begin
        a.key_wr = key;
        a.st_wr  = !key;
        a.wdata  = d[i];
      end
      @(negedge core_clk);
      acc = a;
    end
  endtask : wr16

  // Read data lands one cycle late, so compare the previous byte
  task rd16(input logic key, input bce_pkg::blk_t exp);
    bce_pkg::acc_t a;
    for (int i = 0; i <= 16; i++) begin
      a = '0;
      if (i < 16) begin
        a.key_rd = key;
        a.st_rd  = !key;
      end
      @(negedge core_clk);
      if (i > 0) check({1'b0, rdata_ff}, {1'b0, exp[i-1]});
      acc = a;
    end
  endtask : rd16

  task go(input logic dec);
    @(negedge core_clk);
    ctrl.start   = 1'b1;
    ctrl.decrypt = dec;
    @(negedge core_clk);
    ctrl.start   = 1'b0;
  endtask : go

  // Counts busy cycles; a state write mid-run must be ignored
  task wait_done(input logic ien);
    logic [8:0]    n;
    bce_pkg::acc_t a;
    n = 9'h000;
    check({8'h00, busy_ff}, 9'h001);
    while (busy_ff === 1'b1 && n < RUN_LIMIT) begin
      n = n + 9'h001;
      a = '0;
      if (n == 9'h005) begin
        a.st_wr = 1'b1;
        a.wdata = 8'hA5;
      end
      acc = a;
      @(negedge core_clk);
    end
    if (n == RUN_LIMIT) begin
      error_cnt++;
      conclude();
    end else begin
      check(n, bce_pkg::OP_CYCLES);
      check({8'h00, dma_trig_ff}, 9'h001);
      check({8'h00, irq_ff}, {8'h00, ien});
      @(negedge core_clk);
      check({8'h00, dma_trig_ff}, 9'h000);
      check({8'h00, irq_ff}, 9'h000);
    end
  endtask : wait_done

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task t_encrypt;
    ctrl.irq_en = 1'b1;
    wr16(1'b1, KEY);
    wr16(1'b0, PT);
    go(1'b0);
    wait_done(1'b1);
    rd16(1'b0, CT);
  endtask : t_encrypt

  // No interrupt when disabled; key memory survives
  task t_decrypt;
    ctrl.irq_en = 1'b0;
    wr16(1'b0, CT);
    go(1'b1);
    wait_done(1'b0);
    rd16(1'b0, PT);
    rd16(1'b1, KEY);
  endtask : t_decrypt

  // Plain overwrite would leave inverted data and a wrong cipher block
  task t_auto_xor;
    ctrl.irq_en = 1'b1;
    wr16(1'b0, {16{8'hFF}});
    ctrl.decrypt    = 1'b0;
    ctrl.xor_load   = 1'b1;
    ctrl.auto_start = 1'b1;
    wr16(1'b0, PT ^ {16{8'hFF}});
    wait_done(1'b1);
    ctrl.xor_load   = 1'b0;
    ctrl.auto_start = 1'b0;
    rd16(1'b0, CT);
  endtask : t_auto_xor

  // Main sequence
  initial begin
    ctrl  = '0;
    acc   = '0;
    rst_b = 1'b0;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    check({8'h00, busy_ff}, 9'h000);
    t_encrypt();
    t_decrypt();
    t_auto_xor();
    conclude();
  end
endmodule : block_cipher_engine_test
